/* File: ppm_core.v */
// Pulse period measurement channel: 16-bit up counter, capture, overflow
// extension and period calculation. Assumes i_pulse_input_pin is async and
// i_count_start_bit comes from logic on i_core_clk.
`timescale 1ns/1ps
`include "ppm_defs.vh"
`default_nettype none
// Operation
// - The counter stays idle until the count start bit is written to one.
// - A rising pulse edge copies the counter to the capture register and clears the counter.
// - Each capture raises a capture interrupt request in the same cycle.
// - The counter free-runs upward and is cleared only by a capture.
// - A counter wrap past its maximum raises an overflow interrupt request.
// - The counter advances once per count clock of peripheral clock divided by DIV_RATIO, sixteen by default.
// - The first capture sets the active flag and clears the overflow count, reporting no period.
// - While active, each overflow adds one to the overflow count.
// - Each later capture yields resolution times (overflows times 10000h plus capture).
// - An overflow count beyond 65535 raises the error output and stops measuring.
// - Capture takes level 3, overflow level 4, and overflow is handled first.
// - The error is driven on a plain general-purpose output pin.
// - The time per count is a parameter defaulting to 100 ns.
// - A rising edge at FFFFh captures FFFFh, clears the counter and requests capture.
// - A wrap that meets a capture is suppressed, so no overflow is counted for it.
module ppm_core #(
    parameter DIV_RATIO = `PPM_DIV_RATIO,
    parameter RES_NS = `PPM_RES_NS
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_count_start_bit,
    input wire i_pulse_input_pin,
    output wire [`PPM_CNT_W-1:0] o_timer_count,
    output wire [`PPM_CNT_W-1:0] o_capture_reg_a,
    output wire o_capture_a_irq,
    output wire o_overflow_irq,
    output wire [3:0] o_capture_a_irq_level,
    output wire [3:0] o_overflow_irq_level,
    output wire o_measure_active,
    output wire [`PPM_OVF_W-1:0] o_overflow_count,
    output wire [`PPM_PERIOD_W-1:0] o_period_ns,
    output wire o_period_valid,
    output wire o_error_output_pin
);
    wire rise;
    wire tick;
    wire running;
    reg [`PPM_CNT_W-1:0] cnt_ff;
    reg [`PPM_CNT_W-1:0] nxt_cnt;
    reg [`PPM_CNT_W-1:0] cap_ff;
    reg capt_irq_ff;
    reg ovf_irq_ff;
    reg active_ff;
    reg [`PPM_OVF_W-1:0] ovf_ff;
    reg [`PPM_OVF_W-1:0] nxt_ovf;
    reg [`PPM_PERIOD_W-1:0] period_ff;
    reg valid_ff;
    reg err_ff;
    reg run_ff;
    wire capture;
    wire wrap;
    wire [`PPM_OVF_W-1:0] ovf_eff;
    wire [`PPM_PERIOD_W-1:0] raw_counts;

    // Start is sticky once software sets it; error halts the channel
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            run_ff <= 1'b0;
        end else if (err_ff) begin
            run_ff <= 1'b0;
        end else if (i_count_start_bit) begin
            run_ff <= 1'b1;
        end
    end

    ppm_edge_sync u_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_pin(i_pulse_input_pin),
        .o_rise(rise)
    );

    // Count clock of core clock over DIV_RATIO, sixteen by default
    ppm_prescaler #(
        .DIV_RATIO(DIV_RATIO)
    ) u_presc (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(running),
        .o_tick(tick)
    );

    // Error freezes the channel at once, not one cycle late
    assign running = run_ff & ~err_ff;
    // Capture is taken on the core clock, not held back to a count tick
    assign capture = running && rise;
    // Wrap only when the counter would actually roll over
    assign wrap = running && tick && !capture && (cnt_ff == `PPM_CNT_MAX);

    // Free-running up count, cleared only by a capture
    always @* begin
        nxt_cnt = cnt_ff;
        if (capture) begin
            nxt_cnt = `PPM_CNT_RST;
        end else if (running && tick) begin
            nxt_cnt = cnt_ff + 1'b1;
        end
    end

    // Counter and capture register
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_ff <= `PPM_CNT_RST;
            cap_ff <= `PPM_CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
            if (capture) begin
                cap_ff <= cnt_ff;
            end
        end
    end

    // Request pulses, registered so capture lines up with the capture update and overflow with the counter wrap
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            capt_irq_ff <= 1'b0;
            ovf_irq_ff <= 1'b0;
        end else begin
            capt_irq_ff <= capture;
            ovf_irq_ff <= wrap;
        end
    end

    // Fixed priority levels; higher level is serviced first
    assign o_capture_a_irq_level = `PPM_IRQ_LVL_CAPT;
    assign o_overflow_irq_level = `PPM_IRQ_LVL_OVF;

    // A pending overflow is folded in before the capture uses the count
    assign ovf_eff = ovf_ff + {{(`PPM_OVF_W-1){1'b0}}, ovf_irq_ff & active_ff};
    // Overflows times 10000h plus the captured value
    assign raw_counts = {{(`PPM_PERIOD_W-`PPM_OVF_W-`PPM_CNT_W){1'b0}}, ovf_eff, cap_ff};

    // Overflow count bookkeeping
    always @* begin
        nxt_ovf = ovf_ff;
        if (capt_irq_ff) begin
            nxt_ovf = {`PPM_OVF_W{1'b0}};
        end else if (ovf_irq_ff && active_ff) begin
            nxt_ovf = ovf_ff + 1'b1;
        end
    end

    // Measurement state, period and error
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            active_ff <= 1'b0;
            ovf_ff <= {`PPM_OVF_W{1'b0}};
            period_ff <= {`PPM_PERIOD_W{1'b0}};
            valid_ff <= 1'b0;
            err_ff <= 1'b0;
        end else if (err_ff) begin
            // Measurement stays stopped until reset
            valid_ff <= 1'b0;
        end else begin
            ovf_ff <= nxt_ovf;
            valid_ff <= 1'b0;
            if (capt_irq_ff && !active_ff) begin
                active_ff <= 1'b1;
            end else if (capt_irq_ff) begin
                // Resolution times raw counts
                period_ff <= raw_counts * RES_NS;
                valid_ff <= 1'b1;
            end
            // Too long a pulse: give up rather than report a wrong period
            if (!capt_irq_ff && nxt_ovf > `PPM_OVF_LIMIT) begin
                err_ff <= 1'b1;
            end
        end
    end

    assign o_timer_count = cnt_ff;
    assign o_capture_reg_a = cap_ff;
    assign o_capture_a_irq = capt_irq_ff;
    assign o_overflow_irq = ovf_irq_ff;
    assign o_measure_active = active_ff;
    assign o_overflow_count = ovf_ff;
    assign o_period_ns = period_ff;
    assign o_period_valid = valid_ff;
    // Plain output level, no timer function on this pin
    assign o_error_output_pin = err_ff;
endmodule
`default_nettype wire

/* File: ppm_core_chk_sva.sv */
// Port checker for the pulse period channel.
// Assumes one clock domain; bound to every ppm_core.
`timescale 1ns/1ps
`default_nettype none
module ppm_core_chk #(
    parameter DIV_RATIO = 16,
    parameter RES_NS = 100
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_count_start_bit,
    input wire i_pulse_input_pin,
    input wire [15:0] o_timer_count,
    input wire [15:0] o_capture_reg_a,
    input wire o_capture_a_irq,
    input wire o_overflow_irq,
    input wire [3:0] o_capture_a_irq_level,
    input wire [3:0] o_overflow_irq_level,
    input wire o_measure_active,
    input wire [16:0] o_overflow_count,
    input wire [47:0] o_period_ns,
    input wire o_period_valid,
    input wire o_error_output_pin
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    reg started_ff;
    // Remembers a start request; start is sticky in the channel
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst)
            started_ff <= 1'b0;
        else if (i_count_start_bit)
            started_ff <= 1'b1;
    end
    idle_before_start_a: assert property (!started_ff |-> o_timer_count == 16'h0000 && !o_capture_a_irq) else $error("count before start");
    capt_clears_a: assert property (o_capture_a_irq |-> o_timer_count == 16'h0000) else $error("capture did not clear");
    capt_pulse_a: assert property (o_capture_a_irq |=> !o_capture_a_irq) else $error("capture request too long");
    count_step_a: assert property ($changed(o_timer_count) |-> o_timer_count == $past(o_timer_count) + 16'h0001 || o_timer_count == 16'h0000) else $error("bad count step");
    ovf_step_a: assert property ($changed(o_overflow_count) |-> o_overflow_count == $past(o_overflow_count) + 17'h00001 || o_overflow_count == 17'h00000) else $error("bad overflow step");
    valid_order_a: assert property (o_period_valid |-> $past(o_capture_a_irq) && $past(o_measure_active)) else $error("period without capture");
    period_calc_a: assert property (o_period_valid |-> (o_period_ns / RES_NS) % 48'h10000 == o_capture_reg_a) else $error("period formula");
    irq_levels_a: assert property (o_capture_a_irq_level == 4'h3 && o_overflow_irq_level == 4'h4) else $error("irq level");
    error_hold_a: assert property (o_error_output_pin |=> o_error_output_pin && $stable(o_timer_count)) else $error("error not sticky");
    cover property (o_period_valid);
    cover property ($rose(o_measure_active));
    cover property (o_capture_a_irq && o_measure_active);
endmodule
bind ppm_core ppm_core_chk #(.DIV_RATIO(DIV_RATIO), .RES_NS(RES_NS)) u_chk (.*);
`default_nettype wire

/* File: ppm_defs.vh */
// Constants for the pulse period measurement block.
// Included by bare name from the core and prescaler design files of the block.
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH
`define PPM_CNT_W 16
`define PPM_CNT_MAX 16'hFFFF
`define PPM_CNT_RST 16'h0000
`define PPM_OVF_W 17
`define PPM_OVF_LIMIT 17'h0FFFF
`define PPM_DIV_RATIO 16
`define PPM_DIV_W 4
`define PPM_RES_NS 100
`define PPM_PERIOD_W 48
`define PPM_IRQ_LVL_CAPT 4'h3
`define PPM_IRQ_LVL_OVF 4'h4
`endif

/* File: ppm_edge_sync.v */
// Two-flop synchroniser with rising-edge detection for the pulse pin.
// Assumes the pin is asynchronous to i_core_clk.
`timescale 1ns/1ps
`default_nettype none
module ppm_edge_sync (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_pin,
    output wire o_rise
);
    reg meta_ff;
    reg sync_ff;
    reg last_ff;
    // First flop feeds only the second one
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
    // Low-to-high transition, one cycle wide
    assign o_rise = sync_ff & ~last_ff;
endmodule
`default_nettype wire

/* File: ppm_prescaler.v */
// Count-clock prescaler: one-cycle tick every DIV_RATIO core clocks.
// Assumes the core clock is the peripheral clock being divided.
`timescale 1ns/1ps
`include "ppm_defs.vh"
`default_nettype none
module ppm_prescaler #(
    parameter DIV_RATIO = `PPM_DIV_RATIO
) (
    input wire i_core_clk,
    input wire i_sys_rst,
    input wire i_run,
    output wire o_tick
);
    // Cut to the divider width on purpose; ratios above 16 need a wider divider
    localparam integer LAST_I = DIV_RATIO - 1;
    localparam [`PPM_DIV_W-1:0] LAST = LAST_I[`PPM_DIV_W-1:0];
    reg [`PPM_DIV_W-1:0] div_ff;
    // Held at zero while stopped so the first tick is a full period away
    always @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_ff <= {`PPM_DIV_W{1'b0}};
        end else if (!i_run || div_ff == LAST) begin
            div_ff <= {`PPM_DIV_W{1'b0}};
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign o_tick = i_run && (div_ff == LAST);
endmodule
`default_nettype wire

/* File: ppm_pulse_src.sv */
// Pulse source in front of the capture pin.
// Assumes the bench sets the half period, two cycles or more.
`timescale 1ns/1ps
`default_nettype none
module ppm_pulse_src (
    input wire i_core_clk,
    input wire i_run,
    input wire [7:0] i_half,
    output logic o_pin
);
    logic [7:0] cnt_ff;
    // Square wave; stopped source rests low so the next rise is clean
    always @(posedge i_core_clk) begin
        if (!i_run) begin
            cnt_ff <= 8'h01;
            o_pin <= 1'b0;
        end else if (cnt_ff >= i_half) begin
            cnt_ff <= 8'h01;
            o_pin <= !o_pin;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the pulse period channel.
// Assumes the pulse source model drives the pin.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk, rst, start, run, pin, irq_c, irq_o, act, vld, err;
    logic [7:0] half;
    logic [15:0] cnt, cap;
    logic [3:0] lvl_c, lvl_o;
    logic [16:0] ovf;
    logic [47:0] per;
    int mismatches = 0;
    int total_checks = 0;
    ppm_pulse_src i_src (.i_core_clk(clk), .i_run(run), .i_half(half), .o_pin(pin));
    // Divider shortened to 4 to keep runs brief
    ppm_core #(.DIV_RATIO(4), .RES_NS(100)) i_dut (.i_core_clk(clk), .i_sys_rst(rst),
        .i_count_start_bit(start), .i_pulse_input_pin(pin), .o_timer_count(cnt),
        .o_capture_reg_a(cap), .o_capture_a_irq(irq_c), .o_overflow_irq(irq_o),
        .o_capture_a_irq_level(lvl_c), .o_overflow_irq_level(lvl_o),
        .o_measure_active(act), .o_overflow_count(ovf), .o_period_ns(per),
        .o_period_valid(vld), .o_error_output_pin(err));
    initial begin
        clk = 1'b0;
        forever #2 clk = !clk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        start <= 1'b0;
        run <= 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset();
        do_reset();
        #1;
        check({cnt, cap}, 48'h0);
        check({ovf, act, err, vld}, 48'h0);
        check(per, 48'h0);
        check({lvl_c, lvl_o}, 48'h34);
    endtask
    // Pulses before start must leave the channel quiet
    task automatic t_idle();
        @(posedge clk);
        half <= 8'h04;
        run <= 1'b1;
        repeat (60) @(posedge clk);
        run <= 1'b0;
        #1;
        check({cnt, cap, act}, 48'h0);
    endtask
    task automatic t_count();
        logic [15:0] c0;
        @(posedge clk);
        start <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        c0 = cnt;
        repeat (32) @(posedge clk);
        #1;
        check(cnt, c0 + 16'h0008);
    endtask
    task automatic wait_valid();
        int n;
        logic c_seen;
        n = 0;
        c_seen = 1'b0;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (irq_c === 1'b1) begin
                c_seen = 1'b1;
            end
        end while (vld !== 1'b1 && n < 400);
        check(vld, 1'b1);
        check(c_seen, 1'b1);
        check(irq_o, 1'b0);
    endtask
    // Capture boundary may fall either side of a count tick
    task automatic t_period(input logic [7:0] h);
        logic [15:0] k;
        k = h / 2;
        do_reset();
        start <= 1'b1;
        half <= h;
        run <= 1'b1;
        repeat (2) begin
            wait_valid();
            check(act, 1'b1);
            check(cap == k || cap == k - 16'h1, 1'b1);
            check(per == 100 * k || per == 100 * (k - 16'h1), 1'b1);
            check(ovf, 48'h0);
        end
    endtask
    initial begin
        rst = 1'b1;
        start = 1'b0;
        run = 1'b0;
        half = 8'h0A;
        t_reset();
        t_idle();
        t_count();
        t_period(8'h0A);
        t_period(8'h20);
        test_done();
    end
    initial begin
        #80000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
